/* File: src/dio_pkg.sv */
// Shared constants for the direct I/O strobe/acknowledge bus
package dio_pkg;

    // ********************************************************************
    // Bus geometry
    // ********************************************************************
    localparam int DATA_W = 32;
    localparam int NARROW_W = 16;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 16;

    // Direction select levels
    localparam logic DIR_WRITE = 1'b1;
    localparam logic DIR_READ = 1'b0;

    // ********************************************************************
    // Timing figures in nanoseconds, timeout in microseconds, and derived cycle counts
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int SETUP_NS = 360;
    localparam int HOLD_NS = 200;
    localparam int ACK_DWELL_NS = 300;
    localparam int SAMPLE_NS = 160;
    localparam int TIMEOUT_US = 40;

    // Least times round up
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_CYC =
        (ACK_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_CYC =
        (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time rounds down
    localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;

    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // Processor end states
    typedef enum logic [4:0] {
        P_IDLE = 5'h01,
        P_SETUP = 5'h02,
        P_STROBE = 5'h04,
        P_DWELL = 5'h08,
        P_HOLD = 5'h10
    } dio_proc_state_e;

    // Device end states
    typedef enum logic [1:0] {
        D_IDLE = 2'h1,
        D_ACK = 2'h2
    } dio_dev_state_e;

    // Lanes in use: narrow variants carry only the low half
    function automatic logic [DATA_W-1:0] lane_mask(input logic narrow);
        lane_mask = narrow ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction

endpackage

/* File: src/dio_bus_if.sv */
// Shared direct I/O bus joining the processor end and a device end
`timescale 1ns/1ps
interface dio_bus_if;

    // ********************************************************************
    // Wires
    // ********************************************************************
    logic [dio_pkg::DATA_W-1:0] data_proc;
    logic [dio_pkg::DATA_W-1:0] data_proc_oe;
    logic [dio_pkg::DATA_W-1:0] data_dev;
    logic [dio_pkg::DATA_W-1:0] data_dev_oe;
    logic [dio_pkg::DATA_W-1:0] data_line;
    logic [dio_pkg::ADDR_W-1:0] io_addr_lines;
    logic direction_select;
    logic xfer_strobe;
    logic xfer_strobe_ack;
    logic status_in_a;
    logic status_in_b;

    // Undriven line idles at logic zero, like the quiescent cable
    genvar i;
    generate
        for (i = 0; i < dio_pkg::DATA_W; i++) begin : g_line
            assign data_line[i] = (data_proc_oe[i] & data_proc[i]) |
                                  (data_dev_oe[i] & data_dev[i]);
        end
    endgenerate

    modport proc (
        output data_proc, data_proc_oe, io_addr_lines, direction_select,
        output xfer_strobe,
        input data_line, xfer_strobe_ack, status_in_a, status_in_b
    );

    modport dev (
        output data_dev, data_dev_oe, xfer_strobe_ack,
        output status_in_a, status_in_b,
        input data_line, io_addr_lines, direction_select, xfer_strobe
    );

endinterface

/* File: src/dio_cycle_timer.sv */
// Loadable down-counter timing the handshake phases
`timescale 1ns/1ps
module dio_cycle_timer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // Control
    input wire logic load_in,
    input wire logic [dio_pkg::CNT_W-1:0] load_val_in,
    // State
    output logic [dio_pkg::CNT_W-1:0] count_out,
    output logic zero_out
);

    // Counts down and rests at zero
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_out <= dio_pkg::CNT_RST;
        end else if (ce_in) begin
            if (load_in) begin
                count_out <= load_val_in;
            end else if (count_out != dio_pkg::CNT_RST) begin
                count_out <= count_out - 16'h0001;
            end
        end
    end

    assign zero_out = (count_out == dio_pkg::CNT_RST);

endmodule

/* File: src/dio_proc_end.sv */
// Processor end of the direct I/O bus: runs read and write transfers
// How it works
// - 32 shared data lines, low 16 when narrow
// - Data lines undefined outside a transfer
// - Write data stable 360 ns before strobe
// - Write data held 200 ns after strobe
// - Device drives read data with acknowledge
// - Read data settled 160 ns after acknowledge
// - Device holds read data until strobe falls
// - Only the processor drives the address
// - Address set and held like write data
// - Address is effective address low 16 bits
// - Direction high for write, low read
// - Direction set and held like address
// - Strobe stays high until acknowledge
// - Optional timer aborts after 40 us
// - Device drops acknowledge after strobe falls
// - Device keeps status and data stable
// - Only the addressed device acknowledges
// - Strobe drops 300 ns after acknowledge
// - Only the addressed device drives status
`timescale 1ns/1ps
module dio_proc_end #(
    parameter int TIMEOUT_CYCLES = dio_pkg::TIMEOUT_CYC
) (
    // Clock, reset and enable
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    // Bus
    dio_bus_if.proc BUS,
    // Configuration
    input wire logic NARROW_IN,
    input wire logic TIMER_EN_IN,
    // Request
    input wire logic REQ_IN,
    input wire logic WRITE_IN,
    input wire logic [31:0] EADDR_IN,
    input wire logic [dio_pkg::DATA_W-1:0] WDATA_IN,
    // Answer
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic TIMEOUT_OUT,
    output logic [dio_pkg::DATA_W-1:0] RDATA_OUT,
    output logic [1:0] STATUS_OUT
);

    // ********
    // Declarations
    // ********
    localparam logic [dio_pkg::CNT_W-1:0] SETUP_LD =
        dio_pkg::CNT_W'(dio_pkg::SETUP_CYC);
    localparam logic [dio_pkg::CNT_W-1:0] HOLD_LD =
        dio_pkg::CNT_W'(dio_pkg::HOLD_CYC);
    localparam logic [dio_pkg::CNT_W-1:0] DWELL_LD =
        dio_pkg::CNT_W'(dio_pkg::ACK_CYC);
    localparam logic [dio_pkg::CNT_W-1:0] TIMEOUT_LD =
        dio_pkg::CNT_W'(TIMEOUT_CYCLES);
    // Remaining dwell count at which 160 ns have passed
    localparam logic [dio_pkg::CNT_W-1:0] SAMPLE_AT =
        dio_pkg::CNT_W'(dio_pkg::ACK_CYC - dio_pkg::SAMPLE_CYC);

    dio_pkg::dio_proc_state_e state_reg;
    dio_pkg::dio_proc_state_e state_next;
    logic tmr_load;
    logic [dio_pkg::CNT_W-1:0] tmr_val;
    logic [dio_pkg::CNT_W-1:0] tmr_count;
    logic tmr_zero;
    logic strobe_reg;
    logic dir_reg;
    logic narrow_reg;
    logic [dio_pkg::ADDR_W-1:0] addr_reg;
    logic [dio_pkg::DATA_W-1:0] wdata_reg;
    logic [dio_pkg::DATA_W-1:0] oe_reg;
    logic aborted_reg;
    logic take;
    logic timed_out;

    // ********
    // Phase timer
    // ********
    dio_cycle_timer u_timer (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .ce_in(CE_IN),
        .load_in(tmr_load),
        .load_val_in(tmr_val),
        .count_out(tmr_count),
        .zero_out(tmr_zero)
    );

    // Request is only taken while idle; others are dropped
    assign take = (state_reg == dio_pkg::P_IDLE) && REQ_IN;
    // Abort only when the optional timer is switched on
    assign timed_out = TIMER_EN_IN && tmr_zero;

    // ********
    // Sequencer
    // ********
    // Next state and timer loads
    always_comb begin
        state_next = state_reg;
        tmr_load = 1'b0;
        tmr_val = SETUP_LD;
        case (state_reg)
            dio_pkg::P_IDLE: begin
                if (REQ_IN) begin
                    state_next = dio_pkg::P_SETUP;
                    tmr_load = 1'b1;
                    tmr_val = SETUP_LD;
                end
            end
            dio_pkg::P_SETUP: begin
                if (tmr_zero) begin
                    state_next = dio_pkg::P_STROBE;
                    tmr_load = 1'b1;
                    tmr_val = TIMEOUT_LD;
                end
            end
            dio_pkg::P_STROBE: begin
                // Strobe waits for the answer
                if (BUS.xfer_strobe_ack) begin
                    state_next = dio_pkg::P_DWELL;
                    tmr_load = 1'b1;
                    tmr_val = DWELL_LD;
                end else if (timed_out) begin
                    state_next = dio_pkg::P_HOLD;
                    tmr_load = 1'b1;
                    tmr_val = HOLD_LD;
                end
            end
            dio_pkg::P_DWELL: begin
                if (tmr_zero) begin
                    state_next = dio_pkg::P_HOLD;
                    tmr_load = 1'b1;
                    tmr_val = HOLD_LD;
                end
            end
            dio_pkg::P_HOLD: begin
                // Waiting for the acknowledge to drop keeps the next
                // transfer from seeing a stale answer
                if (tmr_zero && !BUS.xfer_strobe_ack) begin
                    state_next = dio_pkg::P_IDLE;
                end
            end
            default: begin
                state_next = dio_pkg::P_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= dio_pkg::P_IDLE;
        end else if (CE_IN) begin
            state_reg <= state_next;
        end
    end

    // ********
    // Bus drive
    // ********
    // Address, direction and data latch at request, held to the end
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            addr_reg <= dio_pkg::ADDR_RST;
            dir_reg <= dio_pkg::DIR_READ;
            wdata_reg <= dio_pkg::DATA_RST;
            narrow_reg <= 1'b0;
        end else if (CE_IN && take) begin
            addr_reg <= EADDR_IN[dio_pkg::ADDR_W-1:0];
            dir_reg <= WRITE_IN ? dio_pkg::DIR_WRITE
                                : dio_pkg::DIR_READ;
            wdata_reg <= WDATA_IN & dio_pkg::lane_mask(NARROW_IN);
            narrow_reg <= NARROW_IN;
        end
    end

    // Data enables only during a write; lines free otherwise
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            oe_reg <= dio_pkg::DATA_RST;
        end else if (CE_IN) begin
            if (take && WRITE_IN) begin
                oe_reg <= dio_pkg::lane_mask(NARROW_IN);
            end else if (state_next == dio_pkg::P_IDLE) begin
                oe_reg <= dio_pkg::DATA_RST;
            end
        end
    end

    // Strobe rises after setup, falls after dwell or abort
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            strobe_reg <= 1'b0;
        end else if (CE_IN) begin
            strobe_reg <= (state_next == dio_pkg::P_STROBE) ||
                          (state_next == dio_pkg::P_DWELL);
        end
    end

    // Address and direction stay put through hold
    assign BUS.io_addr_lines = addr_reg;
    assign BUS.direction_select = dir_reg;
    assign BUS.data_proc = wdata_reg;
    assign BUS.data_proc_oe = oe_reg;
    assign BUS.xfer_strobe = strobe_reg;

    // ********
    // Answer to the user
    // ********
    // Sample once 160 ns into the dwell, well before the strobe drops
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RDATA_OUT <= dio_pkg::DATA_RST;
            STATUS_OUT <= 2'h0;
        end else if (CE_IN && state_reg == dio_pkg::P_DWELL &&
                     tmr_count == SAMPLE_AT) begin
            if (dir_reg == dio_pkg::DIR_READ) begin
                RDATA_OUT <= BUS.data_line &
                             dio_pkg::lane_mask(narrow_reg);
            end
            STATUS_OUT <= {BUS.status_in_b, BUS.status_in_a};
        end
    end

    // Abort flag kept until the next request is taken
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            aborted_reg <= 1'b0;
        end else if (CE_IN) begin
            if (take) begin
                aborted_reg <= 1'b0;
            end else if (state_reg == dio_pkg::P_STROBE &&
                         !BUS.xfer_strobe_ack && timed_out) begin
                aborted_reg <= 1'b1;
            end
        end
    end

    // Busy level and end-of-transfer pulses
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            BUSY_OUT <= 1'b0;
            DONE_OUT <= 1'b0;
            TIMEOUT_OUT <= 1'b0;
        end else if (CE_IN) begin
            BUSY_OUT <= (state_next != dio_pkg::P_IDLE);
            DONE_OUT <= (state_reg == dio_pkg::P_HOLD) &&
                        (state_next == dio_pkg::P_IDLE);
            TIMEOUT_OUT <= (state_reg == dio_pkg::P_HOLD) &&
                           (state_next == dio_pkg::P_IDLE) && aborted_reg;
        end else begin
            DONE_OUT <= 1'b0;
            TIMEOUT_OUT <= 1'b0;
        end
    end

endmodule

/* File: src/dio_dev_end.sv */
// Device end of the direct I/O bus: answers one address
`timescale 1ns/1ps
module dio_dev_end (
    // Clock, reset and enable
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    // Bus
    dio_bus_if.dev BUS,
    // Configuration
    input wire logic [dio_pkg::ADDR_W-1:0] MY_ADDR_IN,
    input wire logic NARROW_IN,
    // User side
    input wire logic READY_IN,
    input wire logic [dio_pkg::DATA_W-1:0] RDATA_IN,
    input wire logic [1:0] STATUS_IN,
    output logic WR_STB_OUT,
    output logic RD_STB_OUT,
    output logic [dio_pkg::DATA_W-1:0] WDATA_OUT
);

    // ********
    // Declarations
    // ********
    dio_pkg::dio_dev_state_e state_reg;
    logic ack_reg;
    logic [1:0] status_reg;
    logic [dio_pkg::DATA_W-1:0] data_reg;
    logic [dio_pkg::DATA_W-1:0] oe_reg;
    logic hit;

    // Answer only to our own address
    assign hit = BUS.xfer_strobe && (BUS.io_addr_lines == MY_ADDR_IN) &&
                 READY_IN;

    // ********
    // Handshake
    // ********
    // Acknowledge with data and status together; release on strobe fall
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= dio_pkg::D_IDLE;
            ack_reg <= 1'b0;
            status_reg <= 2'h0;
            data_reg <= dio_pkg::DATA_RST;
            oe_reg <= dio_pkg::DATA_RST;
        end else if (CE_IN) begin
            case (state_reg)
                dio_pkg::D_IDLE: begin
                    if (hit) begin
                        state_reg <= dio_pkg::D_ACK;
                        ack_reg <= 1'b1;
                        status_reg <= STATUS_IN;
                        if (BUS.direction_select == dio_pkg::DIR_READ) begin
                            data_reg <= RDATA_IN;
                            oe_reg <= dio_pkg::lane_mask(NARROW_IN);
                        end
                    end
                end
                dio_pkg::D_ACK: begin
                    // Held steady until strobe falls
                    if (!BUS.xfer_strobe) begin
                        state_reg <= dio_pkg::D_IDLE;
                        ack_reg <= 1'b0;
                        status_reg <= 2'h0;
                        oe_reg <= dio_pkg::DATA_RST;
                    end
                end
                default: begin
                    state_reg <= dio_pkg::D_IDLE;
                    ack_reg <= 1'b0;
                    oe_reg <= dio_pkg::DATA_RST;
                end
            endcase
        end
    end

    // Stable for the whole acknowledged window
    assign BUS.xfer_strobe_ack = ack_reg;
    assign BUS.status_in_a = status_reg[0];
    assign BUS.status_in_b = status_reg[1];
    assign BUS.data_dev = data_reg;
    assign BUS.data_dev_oe = oe_reg;

    // ********
    // User strobes
    // ********
    // Write data is long stable when the strobe is seen
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            WR_STB_OUT <= 1'b0;
            RD_STB_OUT <= 1'b0;
            WDATA_OUT <= dio_pkg::DATA_RST;
        end else if (CE_IN) begin
            WR_STB_OUT <= (state_reg == dio_pkg::D_IDLE) && hit &&
                          (BUS.direction_select == dio_pkg::DIR_WRITE);
            RD_STB_OUT <= (state_reg == dio_pkg::D_IDLE) && hit &&
                          (BUS.direction_select == dio_pkg::DIR_READ);
            if ((state_reg == dio_pkg::D_IDLE) && hit &&
                (BUS.direction_select == dio_pkg::DIR_WRITE)) begin
                WDATA_OUT <= BUS.data_line & dio_pkg::lane_mask(NARROW_IN);
            end
        end else begin
            WR_STB_OUT <= 1'b0;
            RD_STB_OUT <= 1'b0;
        end
    end

endmodule

/* File: dv/dio_bus_props.sv */
// Concurrent checks on the shared direct I/O bus between both ends
`timescale 1ns/1ps
module dio_bus_props #(
    parameter int TIMEOUT_CYCLES = dio_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    // Bus signals
    input wire logic [dio_pkg::DATA_W-1:0] data_proc,
    input wire logic [dio_pkg::DATA_W-1:0] data_proc_oe,
    input wire logic [dio_pkg::DATA_W-1:0] data_dev,
    input wire logic [dio_pkg::DATA_W-1:0] data_dev_oe,
    input wire logic [dio_pkg::ADDR_W-1:0] io_addr_lines,
    input wire logic direction_select,
    input wire logic xfer_strobe,
    input wire logic xfer_strobe_ack,
    input wire logic status_in_a,
    input wire logic status_in_b
);
    // ********
    // Helper counters
    // ********
    localparam int SETUP_MIN = dio_pkg::SETUP_CYC - 1;
    localparam int HOLD_MIN = dio_pkg::HOLD_CYC - 1;
    localparam int TO_MIN = TIMEOUT_CYCLES - 1;
    logic [80:0] fwd_now;
    logic [80:0] fwd_reg;
    logic [15:0] stab_cnt_reg;
    logic [15:0] low_cnt_reg;
    logic [15:0] hi_cnt_reg;
    logic [15:0] ack_cnt_reg;
    logic ack_seen_reg;
    assign fwd_now = {io_addr_lines, direction_select, data_proc_oe,
                      data_proc & data_proc_oe};
    // Cycles the forward lines have been unchanged
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            fwd_reg <= '0;
            stab_cnt_reg <= '0;
        end else begin
            fwd_reg <= fwd_now;
            if (fwd_now != fwd_reg) stab_cnt_reg <= '0;
            else if (~&stab_cnt_reg) stab_cnt_reg <= stab_cnt_reg + 1'b1;
        end
    end
    // Cycles since strobe fell; saturated so idle changes pass
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) low_cnt_reg <= 16'hffff;
        else if (xfer_strobe) low_cnt_reg <= '0;
        else if (low_cnt_reg != 16'hffff) low_cnt_reg <= low_cnt_reg + 1'b1;
    end
    // Strobe-high and since-acknowledge counts; cleared synchronously
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN || !xfer_strobe) begin
            hi_cnt_reg <= '0;
            ack_cnt_reg <= '0;
            ack_seen_reg <= 1'b0;
        end else begin
            hi_cnt_reg <= hi_cnt_reg + 1'b1;
            ack_seen_reg <= ack_seen_reg | xfer_strobe_ack;
            ack_cnt_reg <= ack_cnt_reg + 16'(ack_seen_reg | xfer_strobe_ack);
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // ********
    // Assertions
    // ********
    a_setup_stable: assert property (
        $rose(xfer_strobe) |-> stab_cnt_reg >= SETUP_MIN)
        else $error("strobe rose before setup time");
    a_hold_after: assert property (
        !xfer_strobe && fwd_now != fwd_reg |-> low_cnt_reg >= HOLD_MIN)
        else $error("forward lines changed inside hold time");
    a_addr_steady: assert property (
        xfer_strobe && $past(xfer_strobe) |-> $stable(io_addr_lines) &&
        $stable(direction_select) && $stable(data_proc & data_proc_oe))
        else $error("forward lines moved while strobe high");
    a_read_released: assert property (
        xfer_strobe && !direction_select |-> data_proc_oe == '0)
        else $error("processor drives data during read");
    a_write_driven: assert property (
        xfer_strobe && direction_select |-> data_proc_oe[15:0] == 16'hffff)
        else $error("processor not driving write data");
    a_strobe_waits: assert property (
        $fell(xfer_strobe) |-> ack_seen_reg || hi_cnt_reg >= TO_MIN)
        else $error("strobe dropped without acknowledge");
    a_dwell_min: assert property (
        $fell(xfer_strobe) && ack_seen_reg |-> ack_cnt_reg >= dio_pkg::ACK_CYC)
        else $error("strobe dropped too soon after acknowledge");
    a_ack_release: assert property (
        $fell(xfer_strobe) |-> ##[1:2] !xfer_strobe_ack)
        else $error("acknowledge not dropped after strobe fell");
    a_ack_answers: assert property (
        $rose(xfer_strobe_ack) |-> xfer_strobe &&
        (direction_select || data_dev_oe != '0))
        else $error("acknowledge without strobe or read data");
    a_dev_steady: assert property (
        xfer_strobe && xfer_strobe_ack && $past(xfer_strobe_ack) |->
        $stable(data_dev & data_dev_oe) &&
        $stable({status_in_a, status_in_b}))
        else $error("device data or status moved during acknowledge");
    a_dev_quiet: assert property (
        !xfer_strobe && !xfer_strobe_ack |->
        data_dev_oe == '0 && !status_in_a && !status_in_b)
        else $error("device drives bus while not acknowledging");
    c_write: cover property ($fell(xfer_strobe) && ack_seen_reg &&
        direction_select);
    c_read: cover property ($fell(xfer_strobe) && ack_seen_reg &&
        !direction_select);
    c_abort: cover property ($fell(xfer_strobe) && !ack_seen_reg);
endmodule

/* File: dv/direct_io_handshake_tb.sv */
// Self-checking bench joining the processor end to a device end
`timescale 1ns/1ps
module direct_io_handshake_tb;
    // ********
    // Bench signals
    // ********
    localparam int TO_CYC = 200;
    localparam logic [15:0] DEV_ADDR = 16'h5a3c;
    typedef struct packed {
        logic wr;
        logic nar;
        logic [31:0] ea;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0] st;
    } dio_row_s;
    dio_row_s rows [4] = '{
        '{1'b1, 1'b0, 32'hffff5a3c, 32'ha5c3_1e96, 32'h0, 2'h1},
        '{1'b1, 1'b1, 32'h12345a3c, 32'hdead_beef, 32'h0, 2'h2},
        '{1'b0, 1'b0, 32'h80005a3c, 32'h0, 32'h3c5a_9617, 2'h3},
        '{1'b0, 1'b1, 32'h00015a3c, 32'h0, 32'hcafe_f00d, 2'h0}};
    logic clk = 1'b0, rst_n = 1'b0, narrow = 1'b0, timer_en = 1'b0;
    logic req = 1'b0, wr = 1'b0, ready = 1'b1;
    logic [31:0] eaddr = '0, wdata = '0, dev_rdata = '0;
    logic [1:0] dev_status = '0;
    logic busy, done, tmo, wr_stb, rd_stb, dir_at_ack, tmo_at_done;
    logic [31:0] rdata, dev_wdata, line_at_ack, m;
    logic [1:0] status;
    logic [15:0] addr_at_ack;
    int n_mismatch = 0, comparisons = 0, n_stb, n_cyc, i;
    // Clock at 250 MHz
    always #2 clk = ~clk;
    dio_bus_if dio_bus_if_i ();
    dio_proc_end #(.TIMEOUT_CYCLES(TO_CYC)) dio_proc_end_i (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .BUS(dio_bus_if_i),
        .NARROW_IN(narrow), .TIMER_EN_IN(timer_en), .REQ_IN(req),
        .WRITE_IN(wr), .EADDR_IN(eaddr), .WDATA_IN(wdata), .BUSY_OUT(busy),
        .DONE_OUT(done), .TIMEOUT_OUT(tmo), .RDATA_OUT(rdata),
        .STATUS_OUT(status));
    dio_dev_end dio_dev_end_i (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .BUS(dio_bus_if_i),
        .MY_ADDR_IN(DEV_ADDR), .NARROW_IN(narrow), .READY_IN(ready),
        .RDATA_IN(dev_rdata), .STATUS_IN(dev_status), .WR_STB_OUT(wr_stb),
        .RD_STB_OUT(rd_stb), .WDATA_OUT(dev_wdata));
    dio_bus_props #(.TIMEOUT_CYCLES(TO_CYC)) dio_bus_props_i (
        .CLK_IN(clk), .RESET_N_IN(rst_n),
        .data_proc(dio_bus_if_i.data_proc),
        .data_proc_oe(dio_bus_if_i.data_proc_oe),
        .data_dev(dio_bus_if_i.data_dev),
        .data_dev_oe(dio_bus_if_i.data_dev_oe),
        .io_addr_lines(dio_bus_if_i.io_addr_lines),
        .direction_select(dio_bus_if_i.direction_select),
        .xfer_strobe(dio_bus_if_i.xfer_strobe),
        .xfer_strobe_ack(dio_bus_if_i.xfer_strobe_ack),
        .status_in_a(dio_bus_if_i.status_in_a),
        .status_in_b(dio_bus_if_i.status_in_b));
    // ********
    // Tasks
    // ********
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check_w(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_b(input logic got, input logic exp);
        check_w({31'h0, got}, {31'h0, exp});
    endtask
    // Bounded wait for completion; keeps the last acknowledged bus view
    task automatic run_xfer(input dio_row_s r);
        {wr, narrow, eaddr, wdata, dev_rdata, dev_status} = r;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        n_stb = 0;
        for (n_cyc = 0; n_cyc < 2000; n_cyc++) begin
            @(posedge clk);
            #1;
            n_stb += int'(wr_stb === 1'b1) + int'(rd_stb === 1'b1);
            if (dio_bus_if_i.xfer_strobe && dio_bus_if_i.xfer_strobe_ack) begin
                line_at_ack = dio_bus_if_i.data_line;
                addr_at_ack = dio_bus_if_i.io_addr_lines;
                dir_at_ack = dio_bus_if_i.direction_select;
            end
            tmo_at_done = tmo;
            if (done === 1'b1) begin
                @(negedge clk);
                return;
            end
        end
        n_mismatch++;
        report_and_stop();
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check_b(busy, 1'b0);
        check_b(dio_bus_if_i.xfer_strobe, 1'b0);
        // Table of ordinary writes and reads, wide and narrow
        for (i = 0; i < 4; i++) begin
            run_xfer(rows[i]);
            m = rows[i].nar ? 32'h0000ffff : 32'hffffffff;
            check_w(32'(addr_at_ack), 32'(rows[i].ea[15:0]));
            check_b(dir_at_ack, rows[i].wr);
            check_b(tmo_at_done, 1'b0);
            check_w({30'h0, status}, {30'h0, rows[i].st});
            check_b(n_stb == 1, 1'b1);
            if (rows[i].wr) begin
                check_w(line_at_ack, rows[i].wd & m);
                check_w(dev_wdata, rows[i].wd & m);
            end else begin
                check_w(line_at_ack, rows[i].rd & m);
                check_w(rdata, rows[i].rd & m);
            end
        end
        // Nobody answers: timer aborts, read data kept
        timer_en = 1'b1;
        run_xfer('{1'b0, 1'b0, 32'h00000bad, 32'h0, 32'h1111_2222, 2'h3});
        check_b(tmo_at_done, 1'b1);
        check_b(n_cyc >= TO_CYC, 1'b1);
        check_w(rdata, 32'h0000f00d);
        // Slow device with timer off: strobe must wait
        timer_en = 1'b0;
        ready = 1'b0;
        fork
            run_xfer(rows[2]);
            begin
                repeat (300) @(negedge clk);
                ready = 1'b1;
            end
        join
        check_b(tmo_at_done, 1'b0);
        check_b(n_cyc > 300, 1'b1);
        check_w(rdata, rows[2].rd);
        // Reset in mid-strobe, then a clean transfer
        @(negedge clk);
        wr = 1'b1;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        repeat (120) @(negedge clk);
        check_b(dio_bus_if_i.xfer_strobe, 1'b1);
        rst_n = 1'b0;
        #1;
        check_b(dio_bus_if_i.xfer_strobe, 1'b0);
        check_b(busy, 1'b0);
        check_w(dio_bus_if_i.data_proc_oe, 32'h0);
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        run_xfer(rows[1]);
        check_w(dev_wdata, 32'h0000beef);
        report_and_stop();
    end
endmodule
